// File: adcc_defines.svh
// register map, field positions, reset values and timing counts of the converter control
// assumes: included by bare name by every file that needs a constant
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// ************************************
// register byte offsets
// ************************************
`define ADCC_OFS_CTRL 8'h00
`define ADCC_OFS_ACCUM 8'h04
`define ADCC_OFS_REFCLK 8'h08
`define ADCC_OFS_CHAN 8'h0C
`define ADCC_OFS_COMMAND 8'h10
`define ADCC_OFS_EVCTRL 8'h14
`define ADCC_OFS_INTCTRL 8'h18
`define ADCC_OFS_INTFLAG 8'h1C
`define ADCC_OFS_RESULT 8'h20
`define ADCC_OFS_WINLO 8'h24
`define ADCC_OFS_WINHI 8'h28
`define ADCC_OFS_WINCTRL 8'h2C
`define ADCC_OFS_DBGCTRL 8'h30
`define ADCC_OFS_SAMPDLY 8'h34

// ************************************
// field positions
// ************************************
`define ADCC_CTRL_ENABLE 0
`define ADCC_CTRL_CONT 1
`define ADCC_CTRL_RESOLUTION_SELECT 2
`define ADCC_CTRL_VARY 3
`define ADCC_FLAG_RESULT_READY_FLAG 0
`define ADCC_FLAG_WIN 1
`define ADCC_REF_LSB 4

// ************************************
// window compare modes
// ************************************
`define ADCC_WIN_OFF 3'h0
`define ADCC_WIN_BELOW 3'h1
`define ADCC_WIN_ABOVE 3'h2
`define ADCC_WIN_INSIDE 3'h3
`define ADCC_WIN_OUTSIDE 3'h4

// ************************************
// reset values and timing
// ************************************
`define ADCC_RST_WORD 32'h0000_0000
`define ADCC_RST_LFSR 4'h9
`define ADCC_ACC_MAX 3'h6
`define ADCC_CONV_LAST 4'hC
`define ADCC_SAMPLE_AT 4'h1

`endif

// File: adcc_pkg.sv
// types shared by the converter control files
// assumes: nothing beyond the defines header
package adcc_pkg;
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONVERT, ADCC_GAP} adcc_state_type;
endpackage : adcc_pkg

// File: adcc_clock_divider_select_if.sv
// link between the sequencer and the converter clock prescaler
// assumes: both ends on pclk
`timescale 1ns/1ps
interface adcc_clock_divider_select_if;
    logic run;
    logic halt;
    logic [2:0] div_sel;
    logic tick;
    modport ctrl (output run, output halt, output div_sel, input tick);
    modport clock_divider_select (input run, input halt, input div_sel, output tick);
endinterface : adcc_clock_divider_select_if

// File: adcc_prescaler.sv
// converter clock prescaler: one tick per 2^(div_sel+1) peripheral clocks
// assumes: pclk domain, presetn asynchronous active low
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    adcc_clock_divider_select_if.clock_divider_select pif
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] lim;

    assign lim = 8'((9'h002 << pif.div_sel) - 9'h001);
    // tick comes out of the counter state, so the edge after start is fixed
    assign pif.tick = pif.run && !pif.halt && (cnt_r == lim); // RL16 RL12

    always_comb begin
        cnt_nxt = cnt_r;
        if (!pif.run) begin
            cnt_nxt = 8'h00; // RL19
        end else if (!pif.halt) begin
            cnt_nxt = (cnt_r == lim) ? 8'h00 : cnt_r + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    idle_reset_a: assert property (@(posedge pclk) disable iff (!presetn) !pif.run |=> cnt_r == 8'h00) // RL19
        else $error("prescaler not held while idle");
    halt_freeze_a: assert property (@(posedge pclk) disable iff (!presetn) pif.halt |-> !pif.tick) // RL12
        else $error("converter clock runs while halted");
endmodule : adcc_prescaler

// File: adcc_top.sv
// successive-approximation converter control with APB register file
// assumes: pclk 25 MHz, presetn asynchronous active low, event and halt inputs synchronous to pclk
//
// Summary of operation
// RL1: channel and reference reach the converter only while enable is one.
// RL2: result is right-justified, 10-bit sample with lsb at bit zero; code gives 8 bits, sar_data[9:2], when resolution select is set.
// RL3: writing one to conversion_go starts; it reads one while busy.
// RL4: single mode clears conversion_go at completion.
// RL5: channel change during conversion waits until that conversion ends.
// RL6: one sample or summed burst per accumulation_count; flag at end.
// RL7: interrupt only when flag, its enable and global enable are one.
// RL8: result_ready_flag is set even with its interrupt disabled.
// RL9: with event_start_enable, each event triggers a conversion.
// RL10: event input is edge sensitive; sets conversion_go, completion clears it.
// RL11: continuous mode restarts at once after each completion, flagging each.
// RL12: debugger halt stops the converter unless run_while_halted is one.
// RL13: software configures everything first and sets enable last.
// RL14: optional random variation of inter-sample delay inside a burst.
// RL15: window compare below, above, inside or outside gates interrupts.
// RL16: converter clock comes from peripheral clock via programmable prescaler.
// RL17: conversion is 13 converter clocks, sample two clocks after start.
// RL18: result_ready_flag clears on result read or writing one to it.
// RL19: start waits for next converter clock; prescaler held while idle.
// RL20: writing zero to conversion_go does nothing.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_event,
    input wire logic cpu_halted,
    input wire logic global_irq_enable,
    output logic irq,
    input wire logic [9:0] sar_data,
    output logic sar_enable,
    output logic [4:0] sar_channel,
    output logic [1:0] sar_reference,
    output logic sar_start,
    output logic sar_sample,
    output logic sar_step
);
    // ************************************
    // register file state
    // ************************************
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [2:0] accumulation_count_r, accumulation_count_nxt;
    logic [2:0] clock_divider_select_r, clock_divider_select_nxt;
    logic [1:0] reference_select_r, reference_select_nxt;
    logic [4:0] positive_input_select_r, positive_input_select_nxt;
    logic event_start_enable_r, event_start_enable_nxt;
    logic [1:0] int_en_r, int_en_nxt;
    logic result_ready_flag_r, result_ready_flag_nxt;
    logic win_flag_r, win_flag_nxt;
    logic [15:0] result_value_r, result_value_nxt;
    logic [15:0] win_lo_r, win_lo_nxt;
    logic [15:0] win_hi_r, win_hi_nxt;
    logic [2:0] win_mode_r, win_mode_nxt;
    logic run_while_halted_r, run_while_halted_nxt;
    logic [3:0] samp_dly_r, samp_dly_nxt;
    logic conversion_go_r, conversion_go_nxt;
    logic [4:0] chan_app_r, chan_app_nxt;
    logic [1:0] ref_app_r, ref_app_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic event_d_r;

    // ************************************
    // sequencer state
    // ************************************
    adcc_pkg::adcc_state_type state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [4:0] gap_r, gap_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic [6:0] nsamp_r, nsamp_nxt;
    logic [3:0] lfsr_r, lfsr_nxt;
    logic sar_start_r, sar_start_nxt;
    logic sar_sample_r, sar_sample_nxt;
    logic sar_step_r;

    logic mapped, wr, rd_setup, rd_access, start_req, tick, last, finish, win_hit;
    logic [6:0] total;
    logic [15:0] sample, sum;
    logic [4:0] delay;

    adcc_clock_divider_select_if pif ();
    adcc_prescaler u_clock_divider_select (
        .pclk(pclk),
        .presetn(presetn),
        .pif(pif)
    );
    // prescaler runs only while a conversion is requested or ongoing
    assign pif.run = conversion_go_r && ctrl_r[`ADCC_CTRL_ENABLE]; // RL19
    assign pif.halt = cpu_halted && !run_while_halted_r; // RL12
    assign pif.div_sel = clock_divider_select_r; // RL16
    assign tick = pif.tick;

    // ************************************
    // APB decode
    // ************************************
    always_comb begin
        unique case (paddr)
            `ADCC_OFS_CTRL, `ADCC_OFS_ACCUM, `ADCC_OFS_REFCLK, `ADCC_OFS_CHAN, `ADCC_OFS_COMMAND,
            `ADCC_OFS_EVCTRL, `ADCC_OFS_INTCTRL, `ADCC_OFS_INTFLAG, `ADCC_OFS_RESULT, `ADCC_OFS_WINLO,
            `ADCC_OFS_WINHI, `ADCC_OFS_WINCTRL, `ADCC_OFS_DBGCTRL, `ADCC_OFS_SAMPDLY: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;
    assign wr = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_access = psel && penable && !pwrite && (paddr == `ADCC_OFS_RESULT);

    // ************************************
    // sequencer datapath
    // ************************************
    assign total = 7'h01 << ((accumulation_count_r > `ADCC_ACC_MAX) ? `ADCC_ACC_MAX : accumulation_count_r); // RL6
    assign sample = ctrl_r[`ADCC_CTRL_RESOLUTION_SELECT] ? {8'h00, sar_data[9:2]} : {6'h00, sar_data}; // RL2
    assign sum = acc_r + sample;
    assign last = (state_r == adcc_pkg::ADCC_CONVERT) && tick && (cnt_r == `ADCC_CONV_LAST); // RL17
    assign finish = last && (nsamp_r + 7'h01 == total); // RL6
    assign delay = {1'b0, samp_dly_r} + (ctrl_r[`ADCC_CTRL_VARY] ? {3'h0, lfsr_r[1:0]} : 5'h00); // RL14
    assign start_req = ctrl_r[`ADCC_CTRL_ENABLE]
        && ((wr && paddr == `ADCC_OFS_COMMAND && pwdata[0]) // RL3 RL20
        || (event_start_enable_r && start_event && !event_d_r)); // RL9 RL10

    always_comb begin
        unique case (win_mode_r) // RL15
            `ADCC_WIN_BELOW: win_hit = sum < win_lo_r;
            `ADCC_WIN_ABOVE: win_hit = sum > win_hi_r;
            `ADCC_WIN_INSIDE: win_hit = (sum >= win_lo_r) && (sum <= win_hi_r);
            `ADCC_WIN_OUTSIDE: win_hit = (sum < win_lo_r) || (sum > win_hi_r);
            default: win_hit = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        gap_nxt = gap_r;
        acc_nxt = acc_r;
        nsamp_nxt = nsamp_r;
        lfsr_nxt = lfsr_r;
        sar_start_nxt = 1'b0;
        sar_sample_nxt = 1'b0;
        if (!ctrl_r[`ADCC_CTRL_ENABLE]) begin
            state_nxt = adcc_pkg::ADCC_IDLE;
        end else if (tick) begin
            unique case (state_r)
                adcc_pkg::ADCC_IDLE: begin
                    // first converter clock after the request opens the conversion
                    state_nxt = adcc_pkg::ADCC_CONVERT; // RL19
                    cnt_nxt = 4'h0;
                    acc_nxt = 16'h0000;
                    nsamp_nxt = 7'h00;
                    sar_start_nxt = 1'b1;
                end
                adcc_pkg::ADCC_CONVERT: begin
                    cnt_nxt = cnt_r + 4'h1;
                    sar_sample_nxt = (cnt_r == `ADCC_SAMPLE_AT); // RL17
                    if (finish) begin
                        acc_nxt = 16'h0000;
                        nsamp_nxt = 7'h00;
                        cnt_nxt = 4'h0;
                        if (ctrl_r[`ADCC_CTRL_CONT]) begin
                            sar_start_nxt = 1'b1; // RL11
                        end else begin
                            state_nxt = adcc_pkg::ADCC_IDLE; // RL4
                        end
                    end else if (last) begin
                        acc_nxt = sum;
                        nsamp_nxt = nsamp_r + 7'h01;
                        cnt_nxt = 4'h0;
                        lfsr_nxt = {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]}; // RL14
                        if (delay == 5'h00) begin
                            sar_start_nxt = 1'b1;
                        end else begin
                            state_nxt = adcc_pkg::ADCC_GAP;
                            gap_nxt = delay;
                        end
                    end
                end
                adcc_pkg::ADCC_GAP: begin
                    gap_nxt = gap_r - 5'h01;
                    if (gap_r == 5'h01) begin
                        state_nxt = adcc_pkg::ADCC_CONVERT;
                        sar_start_nxt = 1'b1;
                    end
                end
                default: state_nxt = adcc_pkg::ADCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= adcc_pkg::ADCC_IDLE;
            cnt_r <= 4'h0;
            gap_r <= 5'h00;
            acc_r <= 16'h0000;
            nsamp_r <= 7'h00;
            lfsr_r <= `ADCC_RST_LFSR;
            sar_start_r <= 1'b0;
            sar_sample_r <= 1'b0;
            sar_step_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            acc_r <= acc_nxt;
            nsamp_r <= nsamp_nxt;
            lfsr_r <= lfsr_nxt;
            sar_start_r <= sar_start_nxt;
            sar_sample_r <= sar_sample_nxt;
            sar_step_r <= tick;
        end
    end

    // ************************************
    // register file
    // ************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        accumulation_count_nxt = accumulation_count_r;
        clock_divider_select_nxt = clock_divider_select_r;
        reference_select_nxt = reference_select_r;
        positive_input_select_nxt = positive_input_select_r;
        event_start_enable_nxt = event_start_enable_r;
        int_en_nxt = int_en_r;
        win_lo_nxt = win_lo_r;
        win_hi_nxt = win_hi_r;
        win_mode_nxt = win_mode_r;
        run_while_halted_nxt = run_while_halted_r;
        samp_dly_nxt = samp_dly_r;
        result_value_nxt = finish ? sum : result_value_r; // RL2 RL6
        if (wr) begin
            unique case (paddr)
                `ADCC_OFS_CTRL: ctrl_nxt = pwdata[3:0];
                `ADCC_OFS_ACCUM: accumulation_count_nxt = pwdata[2:0];
                `ADCC_OFS_REFCLK: begin
                    clock_divider_select_nxt = pwdata[2:0];
                    reference_select_nxt = pwdata[`ADCC_REF_LSB +: 2];
                end
                `ADCC_OFS_CHAN: positive_input_select_nxt = pwdata[4:0];
                `ADCC_OFS_EVCTRL: event_start_enable_nxt = pwdata[0];
                `ADCC_OFS_INTCTRL: int_en_nxt = pwdata[1:0];
                `ADCC_OFS_WINLO: win_lo_nxt = pwdata[15:0];
                `ADCC_OFS_WINHI: win_hi_nxt = pwdata[15:0];
                `ADCC_OFS_WINCTRL: win_mode_nxt = pwdata[2:0];
                `ADCC_OFS_DBGCTRL: run_while_halted_nxt = pwdata[0];
                `ADCC_OFS_SAMPDLY: samp_dly_nxt = pwdata[3:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        result_ready_flag_nxt = result_ready_flag_r;
        if (rd_access || (wr && paddr == `ADCC_OFS_INTFLAG && pwdata[`ADCC_FLAG_RESULT_READY_FLAG])) begin
            result_ready_flag_nxt = 1'b0; // RL18
        end
        if (finish) begin
            result_ready_flag_nxt = 1'b1; // RL6 RL8 RL11
        end
        win_flag_nxt = win_flag_r;
        if (wr && paddr == `ADCC_OFS_INTFLAG && pwdata[`ADCC_FLAG_WIN]) begin
            win_flag_nxt = 1'b0;
        end
        if (finish && win_hit) begin
            win_flag_nxt = 1'b1; // RL15
        end
        // writing zero never stops a conversion; continuous stops at a completion only once cont is cleared
        conversion_go_nxt = conversion_go_r; // RL20
        if (!ctrl_r[`ADCC_CTRL_ENABLE]) begin
            conversion_go_nxt = 1'b0;
        end else if (start_req) begin
            conversion_go_nxt = 1'b1; // RL3 RL10
        end else if (finish && !ctrl_r[`ADCC_CTRL_CONT]) begin
            conversion_go_nxt = 1'b0; // RL4 RL10
        end
        // selections follow software only when enabled and outside a conversion
        chan_app_nxt = chan_app_r;
        ref_app_nxt = ref_app_r;
        if (ctrl_r[`ADCC_CTRL_ENABLE] && ((state_r == adcc_pkg::ADCC_IDLE) || finish)) begin // RL1 RL5
            chan_app_nxt = positive_input_select_r;
            ref_app_nxt = reference_select_r;
        end
        prdata_nxt = prdata_r;
        if (rd_setup) begin
            unique case (paddr)
                `ADCC_OFS_CTRL: prdata_nxt = {28'h0, ctrl_r};
                `ADCC_OFS_ACCUM: prdata_nxt = {29'h0, accumulation_count_r};
                `ADCC_OFS_REFCLK: prdata_nxt = {26'h0, reference_select_r, 1'b0, clock_divider_select_r};
                `ADCC_OFS_CHAN: prdata_nxt = {27'h0, positive_input_select_r};
                `ADCC_OFS_COMMAND: prdata_nxt = {31'h0, conversion_go_r}; // RL3
                `ADCC_OFS_EVCTRL: prdata_nxt = {31'h0, event_start_enable_r};
                `ADCC_OFS_INTCTRL: prdata_nxt = {30'h0, int_en_r};
                `ADCC_OFS_INTFLAG: prdata_nxt = {30'h0, win_flag_r, result_ready_flag_r};
                `ADCC_OFS_RESULT: prdata_nxt = {16'h0, result_value_r};
                `ADCC_OFS_WINLO: prdata_nxt = {16'h0, win_lo_r};
                `ADCC_OFS_WINHI: prdata_nxt = {16'h0, win_hi_r};
                `ADCC_OFS_WINCTRL: prdata_nxt = {29'h0, win_mode_r};
                `ADCC_OFS_DBGCTRL: prdata_nxt = {31'h0, run_while_halted_r};
                `ADCC_OFS_SAMPDLY: prdata_nxt = {28'h0, samp_dly_r};
                default: prdata_nxt = `ADCC_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 4'h0;
            accumulation_count_r <= 3'h0;
            clock_divider_select_r <= 3'h0;
            reference_select_r <= 2'h0;
            positive_input_select_r <= 5'h00;
            event_start_enable_r <= 1'b0;
            int_en_r <= 2'h0;
            result_ready_flag_r <= 1'b0;
            win_flag_r <= 1'b0;
            result_value_r <= 16'h0000;
            win_lo_r <= 16'h0000;
            win_hi_r <= 16'h0000;
            win_mode_r <= `ADCC_WIN_OFF;
            run_while_halted_r <= 1'b0;
            samp_dly_r <= 4'h0;
            conversion_go_r <= 1'b0;
            chan_app_r <= 5'h00;
            ref_app_r <= 2'h0;
            prdata_r <= `ADCC_RST_WORD;
            event_d_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            accumulation_count_r <= accumulation_count_nxt;
            clock_divider_select_r <= clock_divider_select_nxt;
            reference_select_r <= reference_select_nxt;
            positive_input_select_r <= positive_input_select_nxt;
            event_start_enable_r <= event_start_enable_nxt;
            int_en_r <= int_en_nxt;
            result_ready_flag_r <= result_ready_flag_nxt;
            win_flag_r <= win_flag_nxt;
            result_value_r <= result_value_nxt;
            win_lo_r <= win_lo_nxt;
            win_hi_r <= win_hi_nxt;
            win_mode_r <= win_mode_nxt;
            run_while_halted_r <= run_while_halted_nxt;
            samp_dly_r <= samp_dly_nxt;
            conversion_go_r <= conversion_go_nxt;
            chan_app_r <= chan_app_nxt;
            ref_app_r <= ref_app_nxt;
            prdata_r <= prdata_nxt;
            event_d_r <= start_event;
        end
    end

    // ************************************
    // outputs
    // ************************************
    // window flag only raises the line when its own enable is set
    assign irq = global_irq_enable
        && ((result_ready_flag_r && int_en_r[`ADCC_FLAG_RESULT_READY_FLAG]) || (win_flag_r && int_en_r[`ADCC_FLAG_WIN])); // RL7
    assign sar_enable = ctrl_r[`ADCC_CTRL_ENABLE];
    assign sar_channel = chan_app_r;
    assign sar_reference = ref_app_r;
    assign sar_start = sar_start_r;
    assign sar_sample = sar_sample_r;
    assign sar_step = sar_step_r;

    // ************************************
    // assertions
    // ************************************
    default clocking dflt_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    busy_reads_a: assert property (state_r != adcc_pkg::ADCC_IDLE |-> conversion_go_r) // RL3
        else $error("conversion_go low during conversion");
    single_clear_a: assert property (finish && !ctrl_r[`ADCC_CTRL_CONT] && !start_req |=> !conversion_go_r) // RL4
        else $error("single mode did not clear conversion_go");
    chan_lock_a: assert property (state_r != adcc_pkg::ADCC_IDLE && !finish |=> $stable(chan_app_r)) // RL5
        else $error("channel changed inside a conversion");
    flag_set_a: assert property (finish |=> result_ready_flag_r && result_value_r == $past(sum)) // RL6 RL8
        else $error("completion did not flag result");
    irq_gate_a: assert property (irq |-> global_irq_enable && (result_ready_flag_r || win_flag_r)) // RL7
        else $error("interrupt without flag or global enable");
    event_start_a: assert property (ctrl_r[0] && event_start_enable_r && $rose(start_event) |=> conversion_go_r) // RL9 RL10
        else $error("event edge did not start conversion");
    cont_restart_a: assert property (finish && ctrl_r[`ADCC_CTRL_CONT] |=> sar_start_r && conversion_go_r) // RL11
        else $error("continuous mode did not restart");
    conv_len_a: assert property (state_r == adcc_pkg::ADCC_CONVERT |-> cnt_r <= `ADCC_CONV_LAST) // RL17
        else $error("conversion longer than 13 converter clocks");
    enable_gate_a: assert property (!ctrl_r[`ADCC_CTRL_ENABLE] |=> $stable(chan_app_r) && $stable(ref_app_r)) // RL1
        else $error("selection applied while disabled");
    read_clear_a: assert property (rd_access && !finish |=> !result_ready_flag_r) // RL18
        else $error("result read did not clear flag");
    zero_write_a: assert property (wr && paddr == `ADCC_OFS_COMMAND && !pwdata[0] && conversion_go_r
        && !finish && ctrl_r[0] |=> conversion_go_r) // RL20
        else $error("zero write stopped conversion");
endmodule : adcc_top

// File: adcc_sar_model.sv
// analogue core stand-in: holds a code made from the channel at the sample instant
// assumes: sar_* signals come from the converter control on pclk
`timescale 1ns/1ps
module adcc_sar_model (
    input wire logic pclk,
    input wire logic sar_enable,
    input wire logic [4:0] sar_channel,
    input wire logic sar_sample,
    output logic [9:0] sar_data
);
    logic [9:0] held_r = 10'h000;
    always @(posedge pclk) begin
        if (sar_sample) begin
            held_r <= {sar_channel, 5'h0A};
        end
    end
    // a powered-down core gives no valid code, so show a changed value
    assign sar_data = sar_enable ? held_r : ~held_r;
endmodule : adcc_sar_model

// File: test_sar_adc_conversion_control.sv
// self-checking bench for the converter control, with a core stand-in
// assumes: zero-wait APB slave at byte addresses, 25 MHz pclk
`timescale 1ns/1ps
`include "adcc_defines.svh"
module test_sar_adc_conversion_control;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, err, cpu_halted = 1'b0, start_event = 1'b0, global_irq_enable = 1'b0, irq;
    logic [9:0] sar_data;
    logic sar_enable, sar_start, sar_sample, sar_step;
    logic [4:0] sar_channel;
    logic [1:0] sar_reference;
    int n_errors = 0, total_checks = 0, i, n_starts = 0;
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (sar_start === 1'b1) n_starts++;
    adcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_event(start_event), .cpu_halted(cpu_halted), .global_irq_enable(global_irq_enable),
        .irq(irq), .sar_data(sar_data), .sar_enable(sar_enable), .sar_channel(sar_channel),
        .sar_reference(sar_reference), .sar_start(sar_start), .sar_sample(sar_sample), .sar_step(sar_step));
    adcc_sar_model partner (.pclk(pclk), .sar_enable(sar_enable), .sar_channel(sar_channel),
        .sar_sample(sar_sample), .sar_data(sar_data));
    // ************************************
    // bus and compare helpers
    // ************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // ************************************
    // scenarios
    // ************************************
    task automatic test_single;
        apb(1'b1, `ADCC_OFS_CHAN, 32'h13, r);
        apb(1'b1, `ADCC_OFS_CTRL, 32'h1, r);
        apb(1'b1, `ADCC_OFS_COMMAND, 32'h1, r);
        apb(1'b0, `ADCC_OFS_COMMAND, 32'h0, r);
        chk(r, 32'h1);
        apb(1'b1, `ADCC_OFS_COMMAND, 32'h0, r);
        apb(1'b0, `ADCC_OFS_COMMAND, 32'h0, r);
        chk(r, 32'h1);
        for (i = 0; i < 60 && r[0] !== 1'b0; i++) apb(1'b0, `ADCC_OFS_COMMAND, 32'h0, r);
        chk(r, 32'h0);
        apb(1'b0, `ADCC_OFS_INTFLAG, 32'h0, r);
        chk(r, 32'h1);
        apb(1'b0, `ADCC_OFS_RESULT, 32'h0, r);
        chk(r, {22'h0, 5'h13, 5'h0A});
        apb(1'b0, `ADCC_OFS_INTFLAG, 32'h0, r);
        chk(r, 32'h0);
        $display("test single done");
    endtask : test_single
    task automatic test_event_irq;
        apb(1'b1, `ADCC_OFS_INTCTRL, 32'h1, r);
        apb(1'b1, `ADCC_OFS_EVCTRL, 32'h1, r);
        global_irq_enable <= 1'b1;
        start_event <= 1'b1;
        for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        // level still high: edge sensitivity means no second run
        apb(1'b0, `ADCC_OFS_COMMAND, 32'h0, r);
        chk(r, 32'h0);
        global_irq_enable <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `ADCC_OFS_INTFLAG, 32'h1, r);
        global_irq_enable <= 1'b1;
        start_event <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h3C, 32'h0, r);
        chk(r, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test event irq done");
    endtask : test_event_irq
    task automatic test_modes;
        cpu_halted <= 1'b1;
        apb(1'b1, `ADCC_OFS_REFCLK, 32'h20, r);
        apb(1'b1, `ADCC_OFS_ACCUM, 32'h1, r);
        apb(1'b1, `ADCC_OFS_WINCTRL, 32'h2, r);
        apb(1'b1, `ADCC_OFS_COMMAND, 32'h1, r);
        repeat (40) @(posedge pclk);
        apb(1'b0, `ADCC_OFS_COMMAND, 32'h0, r);
        chk(r, 32'h1);
        chk({30'h0, sar_reference}, 32'h2);
        apb(1'b1, `ADCC_OFS_DBGCTRL, 32'h1, r);
        for (i = 0; i < 60 && r[0] !== 1'b0; i++) apb(1'b0, `ADCC_OFS_COMMAND, 32'h0, r);
        apb(1'b0, `ADCC_OFS_INTFLAG, 32'h0, r);
        chk(r, 32'h3);
        apb(1'b0, `ADCC_OFS_RESULT, 32'h0, r);
        chk(r, 32'h4D4);
        chk(n_starts, 32'h4);
        apb(1'b1, `ADCC_OFS_ACCUM, 32'h0, r);
        apb(1'b1, `ADCC_OFS_CTRL, 32'h7, r);
        apb(1'b1, `ADCC_OFS_COMMAND, 32'h1, r);
        for (i = 0; i < 60 && r[0] !== 1'b1; i++) apb(1'b0, `ADCC_OFS_INTFLAG, 32'h0, r);
        apb(1'b0, `ADCC_OFS_RESULT, 32'h0, r);
        chk(r, 32'h9A);
        for (i = 0; i < 60 && r[0] !== 1'b1; i++) apb(1'b0, `ADCC_OFS_INTFLAG, 32'h0, r);
        chk(r & 32'h1, 32'h1);
        $display("test modes done");
    endtask : test_modes
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_single();
        test_event_irq();
        test_modes();
        tally_and_finish();
    end
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule : test_sar_adc_conversion_control
